// ===== rcst_cause_dec.sv
// combinational classifier: picks one reset kind from the request pulses
// assumes requests are one-cycle pulses; a higher kind wins a tie
`timescale 1ns/1ps
module rcst_cause_dec (
	input  wire rcst_pkg::rcst_req_t   req,
	input  wire logic                  asleep,
	output rcst_pkg::rcst_event_t      ev
);
	wire is_por   = req.por;
	wire is_bor   = !req.por && req.bor;
	wire is_master_clear_pin  = !req.por && !req.bor && req.master_clear_pin;
	wire is_wdt   = !req.por && !req.bor && !req.master_clear_pin && req.wdt;
	wire is_irq   = !req.por && !req.bor && !req.master_clear_pin && !req.wdt && req.irq_wake && asleep;

	assign ev = is_por  ? rcst_pkg::RCST_EV_POR :
	            is_bor  ? rcst_pkg::RCST_EV_BOR :
	            is_master_clear_pin ? (asleep ? rcst_pkg::RCST_EV_MASTER_CLEAR_PIN_SLP : rcst_pkg::RCST_EV_MASTER_CLEAR_PIN_RUN) :
	            is_wdt  ? (asleep ? rcst_pkg::RCST_EV_WDT_WAKE : rcst_pkg::RCST_EV_WDT_RST) :
	            is_irq  ? rcst_pkg::RCST_EV_IRQ_WAKE : rcst_pkg::RCST_EV_NONE;
endmodule

// ===== rcst_delay_cnt.sv
// down-counter that measures one delay of a programmable length
// assumes start is a one-cycle pulse; a new start restarts the count
`timescale 1ns/1ps
module rcst_delay_cnt #(
	parameter int W = 20
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic [W-1:0] length,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_r;
	logic         busy_r;
	logic         done_r;
	wire          last = busy_r && (cnt_r == '0);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= last && !start;
			if (start) begin
				cnt_r  <= length - W'(1);
				busy_r <= 1'b1;
			end else if (last) begin
				busy_r <= 1'b0;
			end else if (busy_r) begin
				cnt_r <= cnt_r - W'(1);
			end
		end
	end

	assign busy = busy_r;
	assign done = done_r;
endmodule

// ===== rcst_pkg.sv
// package of constants and carriers for the reset-cause status and time-out block
// assumes one 10 MHz clock; reset events arrive as one-cycle pulses
package rcst_pkg;

	localparam int          CLK_HZ          = 10_000_000;
	localparam int          POWERUP_DELAY_TIMER_MS         = 72;
	localparam int          POWERUP_DELAY_TIMER_CYCLES     = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
	localparam int          OST_CYCLES      = 1024;
	localparam logic [12:0] PC_RESET        = 13'h0000;
	localparam logic [12:0] PC_IRQ_VECTOR   = 13'h0004;
	localparam logic [4:0]  COUNTER_HIGH_LATCH_RESET    = 5'h00;
	localparam logic [7:0]  IRQCON_RESET    = 8'h00;
	localparam logic [7:0]  STAT_RESET      = 8'h18;
	localparam int          STAT_TO_BIT     = 4;
	localparam int          STAT_PD_BIT     = 3;
	localparam int          PSR_BOR_BIT     = 0;
	localparam int          PSR_POR_BIT     = 1;
	localparam int          IRQCON_GIE_BIT  = 7;

	typedef enum logic [1:0] {
		RCST_OSC_LP = 2'b00,
		RCST_OSC_XT = 2'b01,
		RCST_OSC_HS = 2'b10,
		RCST_OSC_RC = 2'b11
	} rcst_osc_t;

	typedef enum logic [2:0] {
		RCST_EV_NONE     = 3'b000,
		RCST_EV_POR      = 3'b001,
		RCST_EV_BOR      = 3'b010,
		RCST_EV_MASTER_CLEAR_PIN_RUN = 3'b011,
		RCST_EV_MASTER_CLEAR_PIN_SLP = 3'b100,
		RCST_EV_WDT_RST  = 3'b101,
		RCST_EV_WDT_WAKE = 3'b110,
		RCST_EV_IRQ_WAKE = 3'b111
	} rcst_event_t;

	typedef struct packed {
		logic por;
		logic bor;
		logic master_clear_pin;
		logic wdt;
		logic irq_wake;
	} rcst_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} rcst_bus_t;

	localparam logic [7:0] ADDR_PSR  = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h01;
	localparam logic [7:0] ADDR_CFG  = 8'h02;
	localparam logic [7:0] ADDR_INFO = 8'h03;

endpackage

// ===== rcst_top.sv
// reset-cause recording, register reset values and start-up time-out sequencing
// assumes reset requests are one-cycle pulses from detectors outside; rst_n is the
// digital reset of this logic only and is not one of the recorded resets
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module rcst_top #(
	parameter int POWERUP_DELAY_TIMER_CYCLES = rcst_pkg::POWERUP_DELAY_TIMER_CYCLES,
	parameter int OST_CYCLES  = rcst_pkg::OST_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire rcst_pkg::rcst_req_t req,
	input  wire logic                asleep,
	input  wire rcst_pkg::rcst_osc_t osc_mode,
	input  wire logic                powerup_timer_enable_n,
	input  wire logic                brownout_enable,
	input  wire logic [12:0]         pc_now,
	input  wire logic [7:0]          irq_wake_flags,
	input  wire rcst_pkg::rcst_bus_t bus,
	output logic [7:0]               rdata,
	output logic                     core_reset,
	output logic                     pc_load,
	output logic [12:0]              program_counter,
	output logic [7:0]               status_reg,
	output logic [4:0]               counter_high_latch,
	output logic [7:0]               irq_control_reg,
	output logic                     cause_illegal,
	output logic                     undef_regs
);
	localparam int CW = 20;

	////////////////////////////////////////////////////////////////////////////////
	// event classification

	rcst_pkg::rcst_event_t ev;

	rcst_cause_dec u_dec (
		.req    (req),
		.asleep (asleep),
		.ev     (ev)
	);

	wire ev_por   = (ev == rcst_pkg::RCST_EV_POR);
	wire ev_bor   = (ev == rcst_pkg::RCST_EV_BOR);
	wire ev_mrun  = (ev == rcst_pkg::RCST_EV_MASTER_CLEAR_PIN_RUN);
	wire ev_mslp  = (ev == rcst_pkg::RCST_EV_MASTER_CLEAR_PIN_SLP);
	wire ev_wrst  = (ev == rcst_pkg::RCST_EV_WDT_RST);
	wire ev_wwake = (ev == rcst_pkg::RCST_EV_WDT_WAKE);
	wire ev_iwake = (ev == rcst_pkg::RCST_EV_IRQ_WAKE);
	wire ev_any   = (ev != rcst_pkg::RCST_EV_NONE);
	wire ev_reset = ev_por || ev_bor || ev_mrun || ev_mslp || ev_wrst;
	wire ev_wake  = ev_wwake || ev_iwake;

	////////////////////////////////////////////////////////////////////////////////
	// time-out selection

	wire crystal     = (osc_mode != rcst_pkg::RCST_OSC_RC);
	wire powerup_delay_timer_on     = !powerup_timer_enable_n || brownout_enable;
	// brown-out always runs the power-up timer; power-on only when the timer or brown-out reset is enabled
	wire need_powerup_delay_timer   = (ev_por && powerup_delay_timer_on) || ev_bor;
	wire need_ost    = crystal && (ev_por || ev_bor || ev_wwake || ev_iwake);

	// idle, power-up delay, start-up count; any new event restarts the sequence from the top
	typedef enum logic [1:0] {
		RCST_SQ_IDLE = 2'b00,
		RCST_SQ_POWERUP_DELAY_TIMER = 2'b01,
		RCST_SQ_OST  = 2'b10
	} rcst_seq_t;

	rcst_seq_t seq_r;
	rcst_seq_t seq_nxt;
	logic      ost_pend_r;
	logic      powerup_delay_timer_start;
	logic      ost_start;
	logic      powerup_delay_timer_done;
	logic      ost_done;

	// the power-up delay is counted on the core clock; a separate slow timing source is not modelled
	rcst_delay_cnt #(.W(CW)) u_powerup_delay_timer (
		.clk    (clk),
		.rst_n  (rst_n),
		.start  (powerup_delay_timer_start),
		.length (CW'(POWERUP_DELAY_TIMER_CYCLES)),
		.busy   (),
		.done   (powerup_delay_timer_done)
	);

	rcst_delay_cnt #(.W(CW)) u_ost (
		.clk    (clk),
		.rst_n  (rst_n),
		.start  (ost_start),
		.length (CW'(OST_CYCLES)),
		.busy   (),
		.done   (ost_done)
	);

	assign powerup_delay_timer_start = ev_any && need_powerup_delay_timer;
	// start-up count follows the power-up delay, or starts at once without one
	wire ost_direct   = ev_any && need_ost && !need_powerup_delay_timer;
	wire ost_after    = (seq_r == RCST_SQ_POWERUP_DELAY_TIMER) && powerup_delay_timer_done && ost_pend_r && !ev_any;
	assign ost_start  = ost_direct || ost_after;

	always_comb begin
		seq_nxt = seq_r;
		unique case (seq_r)
			RCST_SQ_IDLE: begin
				if (powerup_delay_timer_start)
					seq_nxt = RCST_SQ_POWERUP_DELAY_TIMER;
				else if (ost_start)
					seq_nxt = RCST_SQ_OST;
			end
			RCST_SQ_POWERUP_DELAY_TIMER: begin
				if (powerup_delay_timer_start)
					seq_nxt = RCST_SQ_POWERUP_DELAY_TIMER;
				else if (ev_any && ost_start)
					seq_nxt = RCST_SQ_OST;
				else if (ev_any)
					seq_nxt = RCST_SQ_IDLE;
				else if (powerup_delay_timer_done)
					seq_nxt = ost_pend_r ? RCST_SQ_OST : RCST_SQ_IDLE;
			end
			RCST_SQ_OST: begin
				if (powerup_delay_timer_start)
					seq_nxt = RCST_SQ_POWERUP_DELAY_TIMER;
				else if (ev_any && !ost_start)
					seq_nxt = RCST_SQ_IDLE;
				else if (ost_done && !ev_any)
					seq_nxt = RCST_SQ_IDLE;
			end
			default: seq_nxt = RCST_SQ_IDLE;
		endcase
	end

	// hold reset while a reset kind is counting; a wake-up counts its start-up delay
	// without raising core_reset, so a reset kind arriving later still takes over
	logic hold_r;
	logic wake_pend_r;

	wire wake_nxt = ev_any ? ev_wake : (wake_pend_r && seq_nxt != RCST_SQ_IDLE);
	wire hold_nxt = ((seq_nxt != RCST_SQ_IDLE) && !wake_nxt) || ev_reset;

	always_ff @(posedge clk) begin
		if (!rst_n)
			seq_r <= RCST_SQ_IDLE;
		else
			seq_r <= seq_nxt;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			ost_pend_r <= 1'b0;
		else if (ev_any)
			ost_pend_r <= need_ost;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			hold_r <= 1'b1;
		else
			hold_r <= hold_nxt;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			wake_pend_r <= 1'b0;
		else
			wake_pend_r <= wake_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// power status flags: cleared only by rst_n, a software write or their own event, never by other recorded resets

	logic [1:0] psr_r;
	logic [1:0] psr_nxt;
	wire        psr_we = bus.we && (bus.addr == rcst_pkg::ADDR_PSR);

	always_comb begin
		psr_nxt = psr_r;
		if (psr_we)
			psr_nxt = bus.wdata[1:0];
		// a power-on or brown-out event on the same cycle as a write wins over it
		if (ev_por)
			psr_nxt[rcst_pkg::PSR_POR_BIT] = 1'b0;
		if (ev_bor)
			psr_nxt[rcst_pkg::PSR_BOR_BIT] = 1'b0;
		// watchdog reset finds both flags set by software; keep them as they are
		if (ev_wrst)
			psr_nxt = psr_r;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			psr_r <= 2'h0;
		else
			psr_r <= psr_nxt;
	end

	// with brown-out reset disabled the flag is not meaningful; it reads as zero
	wire bor_valid = brownout_enable;

	////////////////////////////////////////////////////////////////////////////////
	// status timeout/powerdown and per-reset values

	logic [7:0]  stat_r;
	logic [7:0]  stat_nxt;
	logic [12:0] pc_r;
	logic [12:0] pc_nxt;
	logic [4:0]  pclh_r;
	logic [7:0]  irqc_r;
	logic        pc_load_r;
	logic        undef_r;
	wire         global_irq_enable = irqc_r[rcst_pkg::IRQCON_GIE_BIT];

	always_comb begin
		stat_nxt = stat_r;
		if (ev_por || ev_bor)
			stat_nxt = {3'h0, 1'b1, 1'b1, stat_r[2:0]};
		else if (ev_mrun)
			stat_nxt = {3'h0, stat_r[4:0]};
		else if (ev_mslp)
			stat_nxt = {3'h0, 1'b1, 1'b0, stat_r[2:0]};
		else if (ev_wrst)
			stat_nxt = {3'h0, 1'b0, 1'b1, stat_r[2:0]};
		else if (ev_wwake)
			stat_nxt = {stat_r[7:5], 1'b0, 1'b0, stat_r[2:0]};
		else if (ev_iwake)
			stat_nxt = {stat_r[7:5], 1'b1, 1'b0, stat_r[2:0]};
	end

	assign pc_nxt = ev_reset ? rcst_pkg::PC_RESET :
	                (ev_iwake && global_irq_enable) ? rcst_pkg::PC_IRQ_VECTOR :
	                pc_now + 13'h0001;

	wire irqc_we = bus.we && (bus.addr == rcst_pkg::ADDR_INFO);
	wire cfg_we  = bus.we && (bus.addr == rcst_pkg::ADDR_CFG);

	always_ff @(posedge clk) begin
		if (!rst_n)
			stat_r <= rcst_pkg::STAT_RESET;
		else
			stat_r <= stat_nxt;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			pc_load_r <= 1'b0;
		else
			pc_load_r <= ev_any;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			pc_r <= rcst_pkg::PC_RESET;
		else if (ev_any)
			pc_r <= pc_nxt;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			pclh_r <= rcst_pkg::COUNTER_HIGH_LATCH_RESET;
		else if (ev_reset)
			pclh_r <= rcst_pkg::COUNTER_HIGH_LATCH_RESET;
	end

	// a software write loses to a same-cycle reset or wake-up
	always_ff @(posedge clk) begin
		if (!rst_n)
			irqc_r <= rcst_pkg::IRQCON_RESET;
		else if (ev_reset)
			irqc_r <= {7'h00, irqc_r[0]};
		else if (ev_wake)
			irqc_r <= irqc_r | irq_wake_flags;
		else if (irqc_we)
			irqc_r <= bus.wdata;
	end

	// unknown-valued registers are flagged rather than scrambled; the flag
	// survives every other event and is cleared only by rst_n or by a config register write in a cycle with no event
	always_ff @(posedge clk) begin
		if (!rst_n)
			undef_r <= 1'b0;
		else if (ev_por || ev_bor)
			undef_r <= 1'b1;
		else if (cfg_we && !ev_any)
			undef_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// legality of the recorded cause

	wire illegal = !psr_r[rcst_pkg::PSR_POR_BIT] &&
	               (!stat_r[rcst_pkg::STAT_TO_BIT] || !stat_r[rcst_pkg::STAT_PD_BIT]);

	logic illegal_r;

	always_ff @(posedge clk) begin
		if (!rst_n)
			illegal_r <= 1'b0;
		else
			illegal_r <= illegal;
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read port

	wire [7:0] rd_psr  = {6'h00, psr_r[1], psr_r[0] & bor_valid};
	wire [7:0] rd_stat = stat_r;
	wire [7:0] rd_cfg  = {5'h00, undef_r, seq_r};
	wire [7:0] rd_info = irqc_r;
	wire [7:0] rd_mux  = (bus.addr == rcst_pkg::ADDR_PSR)  ? rd_psr  :
	                     (bus.addr == rcst_pkg::ADDR_STAT) ? rd_stat :
	                     (bus.addr == rcst_pkg::ADDR_CFG)  ? rd_cfg  :
	                     (bus.addr == rcst_pkg::ADDR_INFO) ? rd_info : 8'h00;

	logic [7:0] rdata_r;

	always_ff @(posedge clk) begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else
			rdata_r <= bus.re ? rd_mux : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign rdata              = rdata_r;
	assign core_reset         = hold_r;
	assign pc_load            = pc_load_r;
	assign program_counter    = pc_r;
	assign status_reg         = stat_r;
	assign counter_high_latch = pclh_r;
	assign irq_control_reg    = irqc_r;
	assign cause_illegal      = illegal_r;
	assign undef_regs         = undef_r;
endmodule

// ===== rcst_top_assertions.sv
// port checker for the reset-cause block
// assumes it is bound to rcst_top and sees only its ports
`timescale 1ns/1ps
module rcst_top_chk #(
	parameter int POWERUP_DELAY_TIMER_CYCLES = 20,
	parameter int OST_CYCLES  = 8
) (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire rcst_pkg::rcst_req_t req,
	input wire logic                asleep,
	input wire logic [12:0]         pc_now,
	input wire logic                core_reset,
	input wire logic                pc_load,
	input wire logic [12:0]         program_counter,
	input wire logic [7:0]          status_reg,
	input wire logic [4:0]          counter_high_latch,
	input wire logic [7:0]          irq_control_reg,
	input wire logic                undef_regs
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
// a higher reset kind wins a tie, so lower kinds are qualified by these
wire logic ev_hi = req.por | req.bor | req.master_clear_pin;
wire logic ev_any = ev_hi | req.wdt | (req.irq_wake & asleep);
wire logic ev_wake = asleep & !ev_hi & (req.wdt | req.irq_wake);
wire logic ev_rst = ev_hi | (req.wdt & !asleep);
////////////////////////////////////////////////////////////////////////////////
sequence s_cleared;
	program_counter == 13'h0000 && counter_high_latch == 5'h00 && irq_control_reg[7:1] == 7'h00;
endsequence
sequence s_held;
	core_reset [*8];
endsequence
property p_load; ev_any |=> pc_load; endproperty
a_load: assert property (p_load) else $error("no load after event");
property p_noload; !ev_any |=> !pc_load; endproperty
a_noload: assert property (p_noload) else $error("load without event");
property p_por; req.por |=> s_cleared ##0 (status_reg[7:3] == 5'h03 && undef_regs); endproperty
a_por: assert property (p_por) else $error("power-on values wrong");
property p_por_hold; req.por |=> s_held; endproperty
a_por_hold: assert property (p_por_hold) else $error("reset released early");
property p_bor; req.bor && !req.por |=> s_cleared ##0 (status_reg[7:3] == 5'h03 && undef_regs);
endproperty
a_bor: assert property (p_bor) else $error("brown-out values wrong");
property p_master_clear_pin_run;
	req.master_clear_pin && !req.por && !req.bor && !asleep |=> s_cleared ##0
		(status_reg[7:5] == 3'h0 && status_reg[4:3] == $past(status_reg[4:3]));
endproperty
a_master_clear_pin_run: assert property (p_master_clear_pin_run) else $error("master-clear values wrong");
property p_master_clear_pin_slp;
	req.master_clear_pin && !req.por && !req.bor && asleep |=> s_cleared ##0 status_reg[7:3] == 5'h02;
endproperty
a_master_clear_pin_slp: assert property (p_master_clear_pin_slp) else $error("sleep master-clear wrong");
property p_wdt_rst; req.wdt && !ev_hi && !asleep |=> s_cleared ##0 status_reg[7:3] == 5'h01;
endproperty
a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset wrong");
property p_wdt_wake;
	req.wdt && ev_wake |=> program_counter == $past(pc_now) + 13'h1 &&
		status_reg[4:3] == 2'h0 && $stable(counter_high_latch);
endproperty
a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");
property p_irq_wake;
	req.irq_wake && !req.wdt && ev_wake |=> status_reg[4:3] == 2'h2 && program_counter ==
		($past(irq_control_reg[7]) ? 13'h0004 : $past(pc_now) + 13'h1);
endproperty
a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake wrong");
property p_wake_run;
	ev_wake && !core_reset |=> !core_reset ##1 ($past(ev_rst) || !core_reset)
		##1 ($past(ev_rst) || $past(ev_rst, 2) || !core_reset);
endproperty
a_wake_run: assert property (p_wake_run) else $error("wake-up held reset");
endmodule

// ===== rcst_top_test.sv
// self-checking bench for the reset-cause block
// assumes shortened delay counts so the run stays brief
`timescale 1ns/1ps
module rcst_top_test;
localparam int P = 20;
localparam int O = 8;
localparam logic [4:0] POR = 5'h10, BOR = 5'h08, MCL = 5'h04, WDT = 5'h02, IRQ = 5'h01;
logic                clk, rst_n, asleep, pten_n, bor_en, core_reset, pc_load;
logic                cause_illegal, undef_regs;
rcst_pkg::rcst_req_t req;
rcst_pkg::rcst_osc_t osc_mode;
rcst_pkg::rcst_bus_t bus;
logic [12:0]         pc_now, program_counter;
logic [7:0]          irq_wake_flags, rdata, status_reg, irq_control_reg;
logic [4:0]          counter_high_latch;
int                  n_mismatch, total_checks;
logic [1:0]          t_mode [6] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h3, 2'h2};
logic [5:0]          t_pten = 6'h06, t_boren = 6'h1D, t_isbor = 6'h18;
int                  t_lo [6] = '{P, O, P + O, P + O, P, P + O};
rcst_top #(.POWERUP_DELAY_TIMER_CYCLES(P), .OST_CYCLES(O)) u_rcst_top (
	.clk(clk), .rst_n(rst_n), .req(req), .asleep(asleep), .osc_mode(osc_mode),
	.powerup_timer_enable_n(pten_n), .brownout_enable(bor_en), .pc_now(pc_now),
	.irq_wake_flags(irq_wake_flags), .bus(bus), .rdata(rdata), .core_reset(core_reset),
	.pc_load(pc_load), .program_counter(program_counter), .status_reg(status_reg),
	.counter_high_latch(counter_high_latch), .irq_control_reg(irq_control_reg),
	.cause_illegal(cause_illegal), .undef_regs(undef_regs));
initial begin
	clk = 0;
	forever #50 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task automatic finish_test;
	$display("checks %0d mismatches %0d", total_checks, n_mismatch);
	if (n_mismatch == 0 && total_checks > 0) begin
		$display("[ PASS ]");
	end else begin
		$display("[ FAIL ]");
	end
	$finish;
endtask
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	total_checks++;
	if (got !== exp) begin
		n_mismatch++;
		$display("mismatch at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge clk);
	bus <= '{a, d, 1'b1, 1'b0};
	@(posedge clk);
	bus.we <= 1'b0;
	#1;
endtask
// read data stand only in the cycle after the strobe
task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
	@(posedge clk);
	bus <= '{a, 8'h00, 1'b0, 1'b1};
	@(posedge clk);
	bus.re <= 1'b0;
	#1;
	chk(16'(rdata & m), 16'(e));
endtask
task automatic fire(input logic [4:0] r);
	@(posedge clk);
	req <= r;
	@(posedge clk);
	req <= '0;
	#1;
endtask
// counts cycles of held reset from the first cycle after the event
task automatic rel(input int lo, input int hi);
	int n;
	n = 0;
	while (core_reset === 1'b1 && n < 500) begin
		@(posedge clk);
		#1;
		n++;
	end
	if (n >= 500) begin
		n_mismatch++;
		$display("mismatch at %0t: reset never released", $time);
		finish_test();
	end else begin
		chk(16'(n >= lo && n <= hi), 16'h0001);
	end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	rst_n = 0;
	req = '0;
	asleep = 0;
	osc_mode = rcst_pkg::RCST_OSC_XT;
	pten_n = 0;
	bor_en = 1;
	pc_now = 13'h0123;
	irq_wake_flags = 8'h02;
	bus = '0;
	repeat (3) @(posedge clk);
	rst_n <= 1;
	@(posedge clk);
	#1;
	chk(16'(core_reset), 16'h0000);
	rdc(8'h7F, 8'hFF, 8'h00);
	fire(POR);
	chk(16'({pc_load, program_counter}), 16'h2000);
	chk(16'({status_reg & 8'hF8, counter_high_latch}), 16'h0300);
	chk(16'({irq_control_reg & 8'hFE, undef_regs}), 16'h0001);
	rel(P + O, P + O + 5);
	chk(16'(cause_illegal), 16'h0000);
	rdc(rcst_pkg::ADDR_PSR, 8'h02, 8'h00);
	wr(rcst_pkg::ADDR_PSR, 8'h03);
	wr(rcst_pkg::ADDR_CFG, 8'h00);
	chk(16'(undef_regs), 16'h0000);
	rdc(rcst_pkg::ADDR_PSR, 8'h03, 8'h03);
	fire(BOR);
	chk(16'(status_reg & 8'hF8), 16'h0018);
	chk(16'(program_counter), 16'h0000);
	chk(16'(undef_regs), 16'h0001);
	rel(P + O, P + O + 5);
	rdc(rcst_pkg::ADDR_PSR, 8'h03, 8'h02);
	wr(rcst_pkg::ADDR_PSR, 8'h03);
	wr(rcst_pkg::ADDR_CFG, 8'h00);
	fire(MCL);
	chk(16'({status_reg & 8'hF8, undef_regs}), 16'h0030);
	rel(0, 500);
	rdc(rcst_pkg::ADDR_PSR, 8'h03, 8'h03);
	fire(WDT);
	chk(16'(status_reg & 8'hF8), 16'h0008);
	chk(16'(program_counter), 16'h0000);
	rel(0, 500);
	rdc(rcst_pkg::ADDR_PSR, 8'h03, 8'h03);
	wr(rcst_pkg::ADDR_STAT, 8'hFF);
	rdc(rcst_pkg::ADDR_STAT, 8'hFF, 8'h08);
	asleep <= 1;
	fire(MCL);
	chk(16'(status_reg & 8'hF8), 16'h0010);
	rel(0, 500);
	fire(WDT);
	chk(16'(status_reg & 8'hF8), 16'h0000);
	chk(16'(program_counter), 16'h0124);
	chk(16'(core_reset), 16'h0000);
	rdc(rcst_pkg::ADDR_CFG, 8'h03, 8'h02);
	wr(rcst_pkg::ADDR_INFO, 8'h00);
	fire(IRQ);
	chk(16'(status_reg & 8'hF8), 16'h0010);
	chk(16'(program_counter), 16'h0124);
	chk(16'(irq_control_reg), 16'h0002);
	wr(rcst_pkg::ADDR_INFO, 8'h80);
	fire(IRQ);
	chk(16'(program_counter), 16'h0004);
	asleep <= 0;
	fire(IRQ);
	chk(16'(pc_load), 16'h0000);
	fire(POR);
	rel(0, 500);
	fire(WDT);
	@(posedge clk);
	#1;
	chk(16'(cause_illegal), 16'h0001);
	wr(rcst_pkg::ADDR_PSR, 8'h03);
	@(posedge clk);
	#1;
	chk(16'(cause_illegal), 16'h0000);
	bor_en <= 0;
	rdc(rcst_pkg::ADDR_PSR, 8'h01, 8'h00);
	for (int i = 0; i < 6; i++) begin
		@(posedge clk);
		osc_mode <= rcst_pkg::rcst_osc_t'(t_mode[i]);
		pten_n <= t_pten[i];
		bor_en <= t_boren[i];
		fire(t_isbor[i] ? BOR : POR);
		rel(t_lo[i], t_lo[i] + 5);
	end
	finish_test();
end
endmodule
bind rcst_top rcst_top_chk #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES), .OST_CYCLES(OST_CYCLES)) u_rcst_top_chk (
	.clk(clk), .rst_n(rst_n), .req(req), .asleep(asleep), .pc_now(pc_now),
	.core_reset(core_reset), .pc_load(pc_load), .program_counter(program_counter),
	.status_reg(status_reg), .counter_high_latch(counter_high_latch),
	.irq_control_reg(irq_control_reg), .undef_regs(undef_regs));
